// *** design/prm_maint.v ***
// layer-1 maintenance: defect mapping, alarm generation, persistence timers
`timescale 1ns/10ps
`include "prm_regs.vh"

module prm_maint #(
  parameter [10:0] LOSS_MS     = `PRM_LOSS_MS,
  parameter [10:0] RECOV_MS    = `PRM_RECOV_MS,
  parameter [11:0] BITS_PER_MS = 12'h800
) (
  // clock and reset
  input  wire       ref_clk,
  input  wire       rst,
  // configuration
  input  wire       network_side,
  input  wire       lfa_report_option2,
  input  wire       excess_crc_rai_enable,
  // receive-side defect status from the framer
  input  wire       rx_loss_of_signal,
  input  wire       rx_loss_of_alignment,
  input  wire       rx_all_ones_detect,
  input  wire       rx_remote_alarm,
  input  wire       rx_crc_block_done,
  input  wire       rx_crc_block_error,
  input  wire       rx_ebit_valid,
  input  wire       rx_ebit,
  input  wire       crc_ratio_excessive,
  // network-side defect inputs
  input  wire       defect_toward_user,
  input  wire       defect_toward_exchange,
  input  wire       power_loss_pin,
  // transmit framing side
  input  wire       tx_frame_data,
  output reg        tx_line_data,
  output reg        line_bit_tick,
  output reg        remote_alarm_indication,
  output reg  [2:0] remote_alarm_bit_pos,
  output reg        all_ones_alarm_signal,
  output reg        tx_ebit_valid,
  output reg        tx_ebit,
  // management flags
  output reg        remote_alarm_received,
  output reg        remote_crc_error,
  output reg        remote_report_seen,
  output reg        normal_frames,
  // layer 2 indications
  output reg        layer1_activate_indication,
  output reg        layer1_deactivate_indication,
  output reg        layer1_active
);

  // power loss arrives from a supervisor outside this clock domain;
  // the two flops add two cycles, well inside one line bit
  reg power_loss_meta;
  reg power_loss_sync;

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      power_loss_meta <= 1'b0;
      power_loss_sync <= 1'b0;
    end
    else
    begin
      power_loss_meta <= power_loss_pin;
      power_loss_sync <= power_loss_meta;
    end
  end

  // fractional divider: 200 MHz is not an integer multiple of the
  // line rate, so a phase accumulator spreads the ticks evenly
  reg  [17:0] bit_phase;
  wire [17:0] phase_sum;
  wire        phase_wrap;

  assign phase_sum  = bit_phase + `PRM_BIT_RATE_KBPS;
  assign phase_wrap = (phase_sum >= `PRM_CLK_KHZ);

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      bit_phase     <= 18'h0_0000;
      line_bit_tick <= 1'b0;
    end
    else
    begin
      line_bit_tick <= phase_wrap;
      if (phase_wrap)
      begin
        bit_phase <= phase_sum - `PRM_CLK_KHZ;
      end
      else
      begin
        bit_phase <= phase_sum;
      end
    end
  end

  // millisecond enable counted in line bit periods
  reg  [11:0] ms_bits;
  reg         ms_tick;

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      ms_bits <= 12'h000;
      ms_tick <= 1'b0;
    end
    else
    begin
      ms_tick <= 1'b0;
      if (line_bit_tick)
      begin
        if (ms_bits == BITS_PER_MS - 12'h001)
        begin
          ms_bits <= 12'h000;
          ms_tick <= 1'b1;
        end
        else
        begin
          ms_bits <= ms_bits + 12'h001;
        end
      end
    end
  end

  // user side folds a received all-ones stream into lost alignment
  wire user_lfa;
  wire align_lost;
  wire crc_allowed;

  assign user_lfa   = rx_loss_of_alignment || rx_all_ones_detect;
  assign align_lost = network_side ? rx_loss_of_alignment : user_lfa;

  // loss of signal still reports until alignment itself drops;
  // network option 2 keeps reporting through lost alignment
  assign crc_allowed = !align_lost ||
                       (network_side && lfa_report_option2);

  // remote alarm causes per side
  wire user_alarm;
  wire net_alarm;
  wire net_all_ones;
  wire next_remote_alarm;
  wire next_all_ones;

  assign user_alarm = rx_loss_of_signal || user_lfa;
  assign net_alarm  = rx_loss_of_signal ||
                      rx_loss_of_alignment ||
                      defect_toward_exchange ||
                      (excess_crc_rai_enable && crc_ratio_excessive);

  // all-ones goes only toward the user, and lost alignment does not raise it
  assign net_all_ones = power_loss_sync || defect_toward_user;

  // received remote alarm and e bits never feed these terms
  assign next_remote_alarm = network_side ? net_alarm : user_alarm;
  assign next_all_ones     = network_side && net_all_ones;

  // alarm outputs follow their causes every cycle so they drop at once
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      remote_alarm_indication <= 1'b0;
      all_ones_alarm_signal   <= 1'b0;
      remote_alarm_bit_pos    <= `PRM_ALARM_BIT_POS;
    end
    else
    begin
      remote_alarm_indication <= next_remote_alarm;
      all_ones_alarm_signal   <= next_all_ones;
      remote_alarm_bit_pos    <= `PRM_ALARM_BIT_POS;
    end
  end

  // all-ones replaces every transmitted bit, framing included,
  // so the far end cannot lock to a frame while the alarm stands
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      tx_line_data <= 1'b1;
    end
    else if (line_bit_tick)
    begin
      tx_line_data <= all_ones_alarm_signal ? 1'b1 : tx_frame_data;
    end
  end

  // e bit reports: one per finished crc block while crc_allowed holds, errored or clean;
  // on the network side only, a network-to-user defect or power loss silences them
  wire report_block;

  assign report_block = rx_crc_block_done && crc_allowed &&
                        !(network_side && net_all_ones);

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      tx_ebit_valid <= 1'b0;
      tx_ebit       <= `PRM_EBIT_CLEAN;
    end
    else
    begin
      tx_ebit_valid <= report_block;
      if (report_block)
      begin
        tx_ebit <= rx_crc_block_error ? `PRM_EBIT_ERRORED
                                      : `PRM_EBIT_CLEAN;
      end
    end
  end

  // received indications are only flagged to management
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      remote_alarm_received <= 1'b0;
      remote_crc_error      <= 1'b0;
      remote_report_seen    <= 1'b0;
    end
    else
    begin
      remote_alarm_received <= rx_remote_alarm;
      remote_crc_error      <= rx_ebit_valid &&
                               (rx_ebit == `PRM_EBIT_ERRORED);
      remote_report_seen    <= rx_ebit_valid;
    end
  end

  // normal operational frames: signal present, aligned, not all-ones
  wire rx_normal;

  assign rx_normal = !rx_loss_of_signal && !user_lfa;

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      normal_frames <= 1'b0;
    end
    else
    begin
      normal_frames <= rx_normal;
    end
  end

  // persistence timers; the first millisecond tick after a state change
  // may come early, so a window can close up to 1 ms short of its setting
  wire loss_expired;
  wire recov_expired;
  wire recov_running;
  wire loss_run;

  // loss timer only counts while abnormal, which is exactly when the
  // recovery timer is held in reset; during normal frames it is paused
  assign loss_run = !normal_frames && !recov_running;

  prm_persist_timer loss_persistence_timer (
    .clk     (ref_clk),
    .rst     (rst),
    .ms_tick (ms_tick),
    .run     (loss_run),
    .clear   (recov_expired),
    .limit   (LOSS_MS),
    .expired (loss_expired),
    .running ()
  );

  prm_persist_timer recovery_persistence_timer (
    .clk     (ref_clk),
    .rst     (rst),
    .ms_tick (ms_tick),
    .run     (normal_frames),
    .clear   (!normal_frames),
    .limit   (RECOV_MS),
    .expired (recov_expired),
    .running (recov_running)
  );

  // layer 2 indications fire once per state change;
  // loss expiry is held until recovery expires, so both expired flags are high for that one cycle and activation is tested first
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      layer1_active                <= 1'b0;
      layer1_activate_indication   <= 1'b0;
      layer1_deactivate_indication <= 1'b0;
    end
    else
    begin
      layer1_activate_indication   <= 1'b0;
      layer1_deactivate_indication <= 1'b0;
      if (recov_expired && !layer1_active)
      begin
        layer1_active              <= 1'b1;
        layer1_activate_indication <= 1'b1;
      end
      else if (loss_expired && layer1_active)
      begin
        layer1_active                <= 1'b0;
        layer1_deactivate_indication <= 1'b1;
      end
    end
  end

endmodule

// *** design/prm_regs.vh ***
// timing constants for the primary rate layer-1 maintenance block
`ifndef PRM_REGS_VH
`define PRM_REGS_VH

// system clock rate in kHz (200 MHz)
`define PRM_CLK_KHZ        18'h3_0D40
// nominal line bit rate in kbit/s (2048)
`define PRM_BIT_RATE_KBPS  18'h0_0800
// bit periods in one millisecond: kbit/s times 1 ms
`define PRM_BITS_PER_MS    (`PRM_BIT_RATE_KBPS)

// loss persistence window in ms, allowed 100 to 1000
`define PRM_LOSS_MIN_MS    11'h064
`define PRM_LOSS_MAX_MS    11'h3E8
`define PRM_LOSS_MS        11'h1F4
// recovery persistence window in ms, allowed 10 to 100
`define PRM_RECOV_MIN_MS   11'h00A
`define PRM_RECOV_MAX_MS   11'h064
`define PRM_RECOV_MS       11'h032

// position of the alarm bit in the non-alignment time slot 0 byte
`define PRM_ALARM_BIT_POS  3'h3
// e bit coding
`define PRM_EBIT_ERRORED   1'h0
`define PRM_EBIT_CLEAN     1'h1

`endif

// *** design/prm_persist_timer.v ***
// millisecond persistence timer with hold, clear and sticky expiry
`timescale 1ns/10ps

module prm_persist_timer (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // control
  input  wire        ms_tick,
  input  wire        run,
  input  wire        clear,
  input  wire [10:0] limit,
  // status
  output reg         expired,
  output wire        running
);

  reg [10:0] count;

  // a held count is kept while run is low, so a paused timer resumes
  always @(posedge clk)
  begin
    if (rst || clear)
    begin
      count   <= 11'h000;
      expired <= 1'b0;
    end
    else if (run && ms_tick && !expired)
    begin
      count <= count + 11'h001;
      if (count == limit - 11'h001)
      begin
        expired <= 1'b1;
      end
    end
  end

  assign running = run && !expired;

endmodule

// *** bench/prm_maint_asserts.sv ***
// assertion checker on the layer-1 maintenance top ports
`timescale 1ns/10ps
module prm_maint_chk (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // configuration and defects
  input wire network_side,
  input wire lfa_report_option2,
  input wire rx_loss_of_signal,
  input wire rx_loss_of_alignment,
  input wire rx_all_ones_detect,
  input wire rx_crc_block_done,
  input wire rx_crc_block_error,
  input wire defect_toward_user,
  // transmit side
  input wire line_bit_tick,
  input wire tx_line_data,
  input wire remote_alarm_indication,
  input wire all_ones_alarm_signal,
  input wire tx_ebit_valid,
  input wire tx_ebit
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_alarm_on_loss: assert property ((rx_loss_of_signal || rx_loss_of_alignment) |=> remote_alarm_indication)
    else $error("remote alarm missing after loss");
  a_user_all_ones: assert property (!network_side && rx_all_ones_detect && rx_crc_block_done
    |=> remote_alarm_indication && !tx_ebit_valid) else $error("all-ones not handled as lost alignment");
  a_lfa_no_ebit: assert property (rx_loss_of_alignment && rx_crc_block_done
    && !(network_side && lfa_report_option2) |=> !tx_ebit_valid) else $error("e bit sent without alignment");
  a_ebit_code: assert property (!network_side && rx_crc_block_done && !rx_loss_of_alignment
    && !rx_all_ones_detect |=> tx_ebit_valid && (tx_ebit == !$past(rx_crc_block_error)))
    else $error("e bit report wrong");
  a_user_rai_clear: assert property (!network_side && !rx_loss_of_signal && !rx_loss_of_alignment
    && !rx_all_ones_detect |=> !remote_alarm_indication) else $error("remote alarm lingers");
  a_net_all_ones: assert property (network_side && defect_toward_user |=> all_ones_alarm_signal)
    else $error("all-ones alarm missing");
  a_line_all_ones: assert property ((line_bit_tick && all_ones_alarm_signal) ##1 all_ones_alarm_signal
    |-> tx_line_data) else $error("line not all ones under alarm");
  a_tick_period: assert property (line_bit_tick |=> !line_bit_tick ##[96:97] line_bit_tick)
    else $error("line bit tick period wrong");
endmodule

bind prm_maint prm_maint_chk u_chk (
  .ref_clk, .rst, .network_side, .lfa_report_option2, .rx_loss_of_signal, .rx_loss_of_alignment,
  .rx_all_ones_detect, .rx_crc_block_done, .rx_crc_block_error, .defect_toward_user, .line_bit_tick,
  .tx_line_data, .remote_alarm_indication, .all_ones_alarm_signal, .tx_ebit_valid, .tx_ebit
);

// *** bench/prm_peer_model.sv ***
// peer equipment model across the user-network interface
`timescale 1ns/10ps
module prm_peer_model (
  // clock and reset
  input  wire       ref_clk,
  input  wire       rst,
  // bench commands
  input  wire       alarm_cmd,
  input  wire       send_cmd,
  input  wire       send_val,
  // line from the device
  input  wire       line_data,
  input  wire       bit_tick,
  // received side toward the device, and the run of ones seen on the line for the bench
  output wire       rx_remote_alarm,
  output reg        rx_ebit_valid,
  output reg        rx_ebit,
  output reg  [7:0] ones_run
);
  assign rx_remote_alarm = alarm_cmd;
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      rx_ebit_valid <= 1'h0;
      rx_ebit       <= 1'h1;
      ones_run      <= 8'h00;
    end
    else
    begin
      rx_ebit_valid <= send_cmd;
      // outside a report the line toggles so a stale bit never reads as data
      rx_ebit       <= send_cmd ? send_val : ~rx_ebit;
      if (bit_tick)
        ones_run <= line_data ? ones_run + {7'h00, ones_run != 8'hFF} : 8'h00;
    end
  end
endmodule

// *** bench/prm_maint_tb.sv ***
// self-checking bench for the layer-1 maintenance block
`timescale 1ns/10ps
module prm_maint_tb;
  logic ref_clk = 1'h0, rst = 1'h1, network_side = 1'h0, lfa_report_option2 = 1'h0;
  logic excess_crc_rai_enable = 1'h0, rx_loss_of_signal = 1'h0, rx_loss_of_alignment = 1'h0;
  logic rx_all_ones_detect = 1'h0, rx_crc_block_done = 1'h0, rx_crc_block_error = 1'h0;
  logic crc_ratio_excessive = 1'h0, defect_toward_user = 1'h0, defect_toward_exchange = 1'h0;
  logic power_loss_pin = 1'h0, tx_frame_data = 1'h0, peer_alarm = 1'h0, peer_send = 1'h0, peer_val = 1'h1;
  wire rx_remote_alarm, rx_ebit_valid, rx_ebit, tx_line_data, line_bit_tick, remote_alarm_indication;
  wire all_ones_alarm_signal, tx_ebit_valid, tx_ebit, remote_alarm_received, remote_crc_error;
  wire remote_report_seen, normal_frames, layer1_activate_indication, layer1_deactivate_indication, layer1_active;
  wire [2:0] remote_alarm_bit_pos;
  wire [7:0] ones_run;
  int errors = 0, n_tests = 0, cycles = 0, acts = 0, deacts = 0;
  // row: {peer alarm, side, option2, excess enable, los, lfa, all ones, excess, to user, to exchange, error, -,
  //       expected remote alarm, all-ones alarm, e bit valid, e bit}
  logic [15:0] rows [15] = '{16'h8022, 16'h080B, 16'h0428, 16'h0228, 16'h1122, 16'hC022, 16'h4428, 16'h642A,
                            16'h480B, 16'h40A4, 16'h404B, 16'h512A, 16'h4122, 16'h0C28, 16'h0022};

  prm_maint #(.LOSS_MS(11'h005), .RECOV_MS(11'h002), .BITS_PER_MS(12'h004)) uut (.ref_clk, .rst, .network_side,
    .lfa_report_option2, .excess_crc_rai_enable, .rx_loss_of_signal, .rx_loss_of_alignment, .rx_all_ones_detect,
    .rx_remote_alarm, .rx_crc_block_done, .rx_crc_block_error, .rx_ebit_valid, .rx_ebit, .crc_ratio_excessive,
    .defect_toward_user, .defect_toward_exchange, .power_loss_pin, .tx_frame_data, .tx_line_data, .line_bit_tick,
    .remote_alarm_indication, .remote_alarm_bit_pos, .all_ones_alarm_signal, .tx_ebit_valid, .tx_ebit,
    .remote_alarm_received, .remote_crc_error, .remote_report_seen, .normal_frames, .layer1_activate_indication,
    .layer1_deactivate_indication, .layer1_active);
  prm_peer_model peer (.ref_clk, .rst, .alarm_cmd(peer_alarm), .send_cmd(peer_send), .send_val(peer_val),
    .line_data(tx_line_data), .bit_tick(line_bit_tick), .rx_remote_alarm, .rx_ebit_valid, .rx_ebit, .ones_run);

  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cycles++;
    if (layer1_activate_indication === 1'h1) acts++;
    if (layer1_deactivate_indication === 1'h1) deacts++;
    if (line_bit_tick === 1'h1) tx_frame_data <= ~tx_frame_data;
    if (cycles == 9000)
    begin
      errors++;
      final_report;
    end
  end

  task automatic run(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    $display("tests=%0d errors=%0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    run(6);
    rst <= 1'h0;
    #1;
    check({tx_line_data, tx_ebit, remote_alarm_bit_pos, remote_alarm_indication, all_ones_alarm_signal,
           layer1_active}, 8'hD8);
    // timers: loss window 5 ms, recovery window 2 ms, 1 ms is about 391 cycles
    run(300); #1; check(8'(acts), 8'h00);
    run(600); #1; check({4'(acts), 3'h0, layer1_active}, 8'h11);
    run(1); rx_loss_of_signal <= 1'h1;
    run(1170); rx_loss_of_signal <= 1'h0;
    #1; check(8'(deacts), 8'h00);
    // a short good spell must only pause the loss timer, so it expires well before 5 ms more
    run(200); rx_loss_of_signal <= 1'h1;
    run(1300); rx_loss_of_signal <= 1'h0;
    #1; check({4'(deacts), 3'h0, layer1_active}, 8'h10);
    run(900); #1; check({4'(acts), 3'h0, layer1_active}, 8'h21);
    run(1); rx_loss_of_signal <= 1'h1;
    run(1300); rx_loss_of_signal <= 1'h0;
    #1; check({4'(deacts), 3'h0, layer1_active}, 8'h11);
    $display("timer tests done");
    foreach (rows[i])
    begin
      run(1);
      {peer_alarm, network_side, lfa_report_option2, excess_crc_rai_enable, rx_loss_of_signal,
       rx_loss_of_alignment, rx_all_ones_detect, crc_ratio_excessive, defect_toward_user,
       defect_toward_exchange, rx_crc_block_error} <= rows[i][15:5];
      rx_crc_block_done <= 1'h1;
      run(1);
      rx_crc_block_done <= 1'h0;
      #1;
      check({4'h0, remote_alarm_indication, all_ones_alarm_signal, tx_ebit_valid, rows[i][1] ? tx_ebit : rows[i][0]},
            {4'h0, rows[i][3:0]});
    end
    $display("mapping tests done");
    run(1); peer_alarm <= 1'h1; peer_val <= 1'h0; peer_send <= 1'h1;
    run(1); peer_send <= 1'h0;
    run(1); #1;
    check({remote_crc_error, remote_report_seen, remote_alarm_received, remote_alarm_indication}, 8'h0E);
    run(1); peer_alarm <= 1'h0; network_side <= 1'h1; defect_toward_user <= 1'h1;
    run(400); #1;
    check({ones_run >= 8'h03, tx_line_data, all_ones_alarm_signal, remote_alarm_indication}, 8'h0E);
    run(1); defect_toward_user <= 1'h0; power_loss_pin <= 1'h1;
    run(4); #1; check({all_ones_alarm_signal, remote_alarm_indication}, 8'h02);
    run(1); power_loss_pin <= 1'h0;
    run(4); #1; check({all_ones_alarm_signal, remote_alarm_indication}, 8'h00);
    $display("line and peer tests done");
    // mid-run reset: outputs idle again, then the layer must reactivate from scratch
    run(1);
    rst <= 1'h1;
    run(2);
    rst <= 1'h0;
    #1;
    check({tx_line_data, tx_ebit, remote_alarm_bit_pos, remote_alarm_indication, all_ones_alarm_signal,
           layer1_active}, 8'hD8);
    run(850);
    #1;
    check({4'(acts), 2'h0, normal_frames, layer1_active}, 8'h33);
    $display("reset tests done");
    final_report;
  end
endmodule
